// ===== shared/i2c_evt_regs.vh
// Constants of the two-wire bus event block: status field positions,
// fixed address patterns and byte framing.
// Assumes inclusion by bare name from the core files.
`ifndef I2C_EVT_REGS_VH
`define I2C_EVT_REGS_VH

// ****************************************************************
// Status word field positions, used by write-one-to-clear
// ****************************************************************
`define STAT_BUS_IF_BIT    1
`define STAT_ARB_LOST_BIT  4

// ****************************************************************
// Address patterns
// ****************************************************************
`define GEN_CALL_ADDR      7'h00
`define TEN_BIT_PREFIX     5'h1e

// ****************************************************************
// Byte framing
// ****************************************************************
`define BITS_PER_BYTE      4'h8
`define ACK_BIT_COUNT      4'h9
`define BIT_COUNT_RESET    4'h0
`define TOP_BIT_INDEX      3'h7
`define BYTE_RESET         8'h00

`endif

// ===== core/line_sync.v
// Two-stage synchroniser with edge detect for a group of bus lines.
// Assumes lines arrive from outside the clk_sys domain.
`timescale 1ns/10ps
module line_sync #(
	parameter WIDTH = 2
) (
	// Clock and reset
	input  wire             clk_sys,
	input  wire             rstn,
	// Raw lines
	input  wire [WIDTH-1:0] line_in,
	// Synchronised level and edges
	output wire [WIDTH-1:0] level,
	output wire [WIDTH-1:0] rise,
	output wire [WIDTH-1:0] fall
);
	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_line
			// Idle bus lines are high, so reset to high
			always @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					stage1[i] <= 1'b1;
					stage2[i] <= 1'b1;
					stage3[i] <= 1'b1;
				end else begin
					stage1[i] <= line_in[i];
					stage2[i] <= stage1[i];
					stage3[i] <= stage2[i];
				end
			end
			assign level[i] = stage2[i];
			assign rise[i]  = stage2[i] & ~stage3[i];
			assign fall[i]  = ~stage2[i] & stage3[i];
		end
	endgenerate
endmodule // line_sync

// ===== core/addr_match.v
// Calling-address comparator for the slave side of the bus block.
// Assumes the byte is stable while the result is used.
`timescale 1ns/10ps
`include "i2c_evt_regs.vh"
module addr_match (
	// Received byte and setup
	input  wire [7:0] rx_byte,
	input  wire [9:0] own_address,
	input  wire       ten_bit_mode,
	input  wire       general_call_enable,
	input  wire       ten_addressed,
	// Results
	output wire       match_seven,
	output wire       match_general,
	output wire       match_ten_first,
	output wire       match_ten_read,
	output wire       match_ten_second
);
	wire prefix_ok;

	assign prefix_ok = (rx_byte[7:3] == `TEN_BIT_PREFIX) &&
		(rx_byte[2:1] == own_address[9:8]);
	assign match_seven = !ten_bit_mode &&
		(rx_byte[7:1] == own_address[6:0]);
	// General call is answered in both addressing modes
	assign match_general = general_call_enable &&
		(rx_byte[7:1] == `GEN_CALL_ADDR);
	// First extended byte must be a write to start addressing
	assign match_ten_first = ten_bit_mode && prefix_ok &&
		!rx_byte[0];
	assign match_ten_read = ten_bit_mode && prefix_ok && rx_byte[0] &&
		ten_addressed;
	assign match_ten_second = (rx_byte == own_address[7:0]);
endmodule // addr_match

// ===== core/i2c_event_core.v
// Event side of the two-wire bus controller: address match, ack,
// transfer-complete, arbitration-lost and the single interrupt.
// Assumes SCL is made elsewhere; lines are open drain, level seen here.
//
// Function
// - General call matched when enable set
// - General call answered as slave receiver
// - General call not acked when disabled
// - Address byte kept in data register
// - Reset disables; no reset request path
// - One interrupt: flag gated by enable
// - Interrupt flag cleared by writing one
// - Byte done, address match, arbitration set flag
// - Transfer complete at ninth clock fall
// - Addressed flag set on own or general
// - Arbitration loss sets flag and interrupt
// - Master data high sampled low loses
// - Master ack high sampled low loses
// - Start request on busy bus loses
// - Repeated start in slave mode loses
// - Unrequested stop loses arbitration
// - Arbitration flag cleared by writing one
// - Master starts on data write only
// - Interrupt after first extended address byte
// - Extended address prefix checked first
// - Losing master releases SDA, no stop
// - Receiver acks low in ninth bit
`timescale 1ns/10ps
`include "i2c_evt_regs.vh"
module i2c_event_core (
	// Clock and reset
	input  wire       clk_sys,
	input  wire       rstn,
	// Bus lines
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output reg        sda_oe,
	// Control bits
	input  wire       module_enable_bit,
	input  wire       bus_interrupt_enable,
	input  wire       general_call_enable,
	input  wire       ten_bit_mode,
	input  wire [9:0] own_address,
	input  wire       master_select_bit,
	input  wire       transmit_select,
	input  wire       ack_disable,
	// Software strobes
	input  wire       start_request,
	input  wire       repeat_start_request,
	input  wire       stop_request,
	input  wire       data_wr,
	input  wire [7:0] data_wdata,
	input  wire       data_rd,
	input  wire       status_wr,
	input  wire [7:0] status_wdata,
	input  wire       control_wr,
	// Status
	output reg        transfer_complete_flag,
	output reg        addressed_as_slave_flag,
	output reg        arbitration_lost_flag,
	output reg        bus_interrupt_flag,
	output reg        slave_direction_bit,
	output reg        bus_busy,
	output reg        master_active,
	output reg  [7:0] bus_data_register,
	output reg        master_launch,
	// Interrupt
	output wire       bus_irq
);
	// ****************************************************************
	// Line synchronisers
	// ****************************************************************
	wire [1:0] lvl;
	wire [1:0] rise;
	wire [1:0] fall;

	line_sync #(.WIDTH(2)) u_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.line_in ({sda_in, scl_in}),
		.level   (lvl),
		.rise    (rise),
		.fall    (fall)
	);

	wire scl_l     = lvl[0];
	wire sda_l     = lvl[1];
	wire scl_rise  = rise[0];
	wire scl_fall  = fall[0];
	wire start_det = fall[1] & scl_l;
	wire stop_det  = rise[1] & scl_l;

	// ****************************************************************
	// Byte state
	// ****************************************************************
	reg [3:0] bit_cnt;
	reg       in_ack;
	reg [7:0] shift_in;
	reg [7:0] tx_byte;
	reg       first_byte;
	reg       slave_addressed;
	reg       ten_pending;
	reg       ten_addressed;
	reg       stop_pending;
	reg       ack_drive;
	reg       byte_owned;
	reg       pend_gc;
	reg       pend_full;
	reg       pend_dir;

	wire m7;
	wire mgc;
	wire mt1;
	wire mtr;
	wire mt2;

	addr_match u_match (
		.rx_byte             (shift_in),
		.own_address         (own_address),
		.ten_bit_mode        (ten_bit_mode),
		.general_call_enable (general_call_enable),
		.ten_addressed       (ten_addressed),
		.match_seven         (m7),
		.match_general       (mgc),
		.match_ten_first     (mt1),
		.match_ten_read      (mtr),
		.match_ten_second    (mt2)
	);

	// ****************************************************************
	// Ack decision and drive
	// ****************************************************************
	wire slave_tx  = slave_addressed & slave_direction_bit;
	wire master_tx = master_active & (first_byte | transmit_select);
	wire data_ph   = bus_busy & !in_ack & (bit_cnt < `BITS_PER_BYTE);
	wire tx_bit    = tx_byte[`TOP_BIT_INDEX - bit_cnt[2:0]];
	wire addr_hit  = first_byte & !master_active & (m7 | mgc | mt1 | mtr);

	reg next_ack;
	reg next_owned;
	reg next_sda_oe;

	always @* begin
		next_ack   = 1'b0;
		next_owned = 1'b0;
		if (master_active) begin
			next_owned = 1'b1;
			// Master receiver acks data bytes unless told not to
			next_ack = !first_byte & !transmit_select & !ack_disable;
		end else if (addr_hit) begin
			// Disabled general call gets no ack and no ownership
			next_ack   = 1'b1;
			next_owned = 1'b1;
		end else if (ten_pending && !first_byte) begin
			next_ack   = mt2;
			next_owned = mt2;
		end else if (slave_addressed) begin
			next_owned = 1'b1;
			next_ack   = !slave_direction_bit & !ack_disable;
		end
	end
	// SDA moves only while SCL is low, except the release on arb_set or disable, which can come with SCL high and fake a stop
	always @* begin
		next_sda_oe = sda_oe;
		if (!scl_l && data_ph && (master_tx || slave_tx))
			next_sda_oe = !tx_bit;
		else if (!scl_l)
			next_sda_oe = in_ack & ack_drive;
	end
	// Open drain: only ever pulls low
	assign sda_out = 1'b0;

	// ****************************************************************
	// Arbitration events
	// ****************************************************************
	// Driving high means the line is released while we own the bit
	wire arb_data = master_active & scl_rise & data_ph & master_tx &
		tx_bit & !sda_l;
	wire arb_ack  = master_active & scl_rise & in_ack & !first_byte &
		!transmit_select & ack_disable & !sda_l;
	wire arb_start = start_request & master_select_bit &
		(bus_busy | start_det);
	wire arb_rep  = repeat_start_request & !master_active;
	wire arb_stop = stop_det & master_active & !stop_pending;
	wire arb_set  = module_enable_bit &
		(arb_data | arb_ack | arb_start | arb_rep | arb_stop);

	wire byte_end = scl_fall & bus_busy & (bit_cnt == `ACK_BIT_COUNT);
	wire tcf_set  = byte_end & byte_owned;
	wire aas_set  = byte_end & (pend_full | pend_gc);

	// ****************************************************************
	// Bus framing and addressing
	// ****************************************************************
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			// Comes up disabled: nothing driven, nothing owned
			bus_busy            <= 1'b0;
			bit_cnt             <= `BIT_COUNT_RESET;
			in_ack              <= 1'b0;
			shift_in            <= `BYTE_RESET;
			tx_byte             <= `BYTE_RESET;
			first_byte          <= 1'b0;
			slave_addressed     <= 1'b0;
			slave_direction_bit <= 1'b0;
			ten_pending         <= 1'b0;
			ten_addressed       <= 1'b0;
			master_active       <= 1'b0;
			stop_pending        <= 1'b0;
			ack_drive           <= 1'b0;
			byte_owned          <= 1'b0;
			pend_gc             <= 1'b0;
			pend_full           <= 1'b0;
			pend_dir            <= 1'b0;
			bus_data_register   <= `BYTE_RESET;
			master_launch       <= 1'b0;
			sda_oe              <= 1'b0;
		end else if (!module_enable_bit) begin
			bus_busy        <= 1'b0;
			bit_cnt         <= `BIT_COUNT_RESET;
			in_ack          <= 1'b0;
			first_byte      <= 1'b0;
			slave_addressed <= 1'b0;
			ten_pending     <= 1'b0;
			ten_addressed   <= 1'b0;
			master_active   <= 1'b0;
			stop_pending    <= 1'b0;
			ack_drive       <= 1'b0;
			master_launch   <= 1'b0;
			sda_oe          <= 1'b0;
		end else begin
			sda_oe <= next_sda_oe & !arb_set;
			// Transfer runs only once software writes the data
			master_launch <= data_wr & master_active;
			if (data_wr)
				tx_byte <= data_wdata;
			if (start_request && master_select_bit && !arb_start)
				master_active <= 1'b1;
			if (stop_request)
				stop_pending <= 1'b1;
			if (start_det) begin
				bus_busy        <= 1'b1;
				bit_cnt         <= `BIT_COUNT_RESET;
				in_ack          <= 1'b0;
				first_byte      <= 1'b1;
				slave_addressed <= 1'b0;
			end else if (stop_det) begin
				bus_busy        <= 1'b0;
				in_ack          <= 1'b0;
				slave_addressed <= 1'b0;
				ten_pending     <= 1'b0;
				ten_addressed   <= 1'b0;
				master_active   <= 1'b0;
				stop_pending    <= 1'b0;
			end else if (scl_rise && bus_busy) begin
				if (bit_cnt < `BITS_PER_BYTE)
					shift_in <= {shift_in[6:0], sda_l};
				if (bit_cnt < `ACK_BIT_COUNT)
					bit_cnt <= bit_cnt + 4'h1;
			end else if (scl_fall && bus_busy) begin
				if (bit_cnt == `BITS_PER_BYTE) begin
					in_ack     <= 1'b1;
					ack_drive  <= next_ack;
					byte_owned <= next_owned;
					pend_gc    <= addr_hit & mgc & !mt1 & !mtr;
					pend_full  <= addr_hit & (m7 | mtr) |
						(ten_pending & !first_byte & mt2);
					pend_dir   <= shift_in[0] & first_byte & !mgc;
				end else if (bit_cnt == `ACK_BIT_COUNT) begin
					in_ack     <= 1'b0;
					ack_drive  <= 1'b0;
					bit_cnt    <= `BIT_COUNT_RESET;
					first_byte <= 1'b0;
					pend_gc    <= 1'b0;
					pend_full  <= 1'b0;
					if (byte_owned)
						bus_data_register <= shift_in;
					if (pend_full | pend_gc) begin
						slave_addressed     <= 1'b1;
						// General call always makes a receiver
						slave_direction_bit <= pend_dir;
						ten_pending         <= 1'b0;
						if (ten_bit_mode)
							ten_addressed <= 1'b1;
					end else if (first_byte && !master_active &&
						mt1 && byte_owned)
						ten_pending <= 1'b1;
				end
			end
			// Losing master lets go at once, makes no stop
			if (arb_set) begin
				master_active <= 1'b0;
				stop_pending  <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Event flags and interrupt
	// ****************************************************************
	wire clr_if  = status_wr & status_wdata[`STAT_BUS_IF_BIT];
	wire clr_arb = status_wr & status_wdata[`STAT_ARB_LOST_BIT];

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			transfer_complete_flag  <= 1'b0;
			addressed_as_slave_flag <= 1'b0;
			arbitration_lost_flag   <= 1'b0;
			bus_interrupt_flag      <= 1'b0;
		end else begin
			// Set wins over a same-cycle clear on every flag
			if (tcf_set)
				transfer_complete_flag <= 1'b1;
			else if (data_rd || data_wr)
				transfer_complete_flag <= 1'b0;
			if (aas_set)
				addressed_as_slave_flag <= 1'b1;
			else if (control_wr || !module_enable_bit)
				addressed_as_slave_flag <= 1'b0;
			if (arb_set)
				arbitration_lost_flag <= 1'b1;
			else if (clr_arb)
				arbitration_lost_flag <= 1'b0;
			// Includes the first extended address byte
			if (tcf_set || aas_set || arb_set)
				bus_interrupt_flag <= 1'b1;
			else if (clr_if)
				bus_interrupt_flag <= 1'b0;
		end
	end

	// Single interrupt line; no reset request exists
	assign bus_irq = bus_interrupt_flag & bus_interrupt_enable;
endmodule // i2c_event_core

// ===== testbench/i2c_event_chk.sv
// Port-level assertions for the two-wire bus event block.
// Assumes one clk_sys domain; bound to every i2c_event_core.
`timescale 1ns/10ps
module i2c_event_chk (
	// Clock and reset
	input wire       clk_sys,
	input wire       rstn,
	// Controls and strobes
	input wire       module_enable_bit,
	input wire       bus_interrupt_enable,
	input wire       master_select_bit,
	input wire       start_request,
	input wire       repeat_start_request,
	input wire       data_wr,
	input wire       status_wr,
	input wire [7:0] status_wdata,
	// Status and bus
	input wire       sda_oe,
	input wire       transfer_complete_flag,
	input wire       addressed_as_slave_flag,
	input wire       arbitration_lost_flag,
	input wire       bus_interrupt_flag,
	input wire       slave_direction_bit,
	input wire       bus_busy,
	input wire       master_active,
	input wire [7:0] bus_data_register,
	input wire       master_launch,
	input wire       bus_irq
);
	// ********
	// Properties
	// ********
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_irq_gated: assert property (
		bus_irq == (bus_interrupt_flag & bus_interrupt_enable))
		else $error("irq differs from gated flag");
	a_if_clear: assert property ($fell(bus_interrupt_flag) |->
		$past(status_wr & status_wdata[1])) else $error("flag lost");
	a_arb_clear: assert property ($fell(arbitration_lost_flag) |->
		$past(status_wr & status_wdata[4])) else $error("arb flag lost");
	a_event_sets_if: assert property (($rose(transfer_complete_flag) ||
		$rose(addressed_as_slave_flag) || $rose(arbitration_lost_flag))
		|-> ##[0:1] bus_interrupt_flag) else $error("event without flag");
	a_busy_start: assert property (start_request && bus_busy &&
		master_select_bit && module_enable_bit && !master_active
		|=> arbitration_lost_flag) else $error("busy start kept");
	a_rstart_slave: assert property (repeat_start_request &&
		module_enable_bit && !master_active |=> arbitration_lost_flag)
		else $error("slave repeat start kept");
	a_lost_release: assert property ($rose(arbitration_lost_flag) |->
		##[0:2] (!master_active && !sda_oe)) else $error("loser drives");
	a_launch_cause: assert property (master_launch |->
		$past(data_wr && master_active && module_enable_bit))
		else $error("launch without data write");
	a_off_quiet: assert property (!module_enable_bit ##1
		!module_enable_bit |-> !sda_oe && !addressed_as_slave_flag)
		else $error("disabled block active");
	a_gc_receiver: assert property ($rose(addressed_as_slave_flag) &&
		bus_data_register == 8'h00 |-> !slave_direction_bit)
		else $error("general call not receive");
endmodule // i2c_event_chk

bind i2c_event_core i2c_event_chk u_chk (
	.clk_sys(clk_sys), .rstn(rstn), .module_enable_bit(module_enable_bit),
	.bus_interrupt_enable(bus_interrupt_enable),
	.master_select_bit(master_select_bit), .start_request(start_request),
	.repeat_start_request(repeat_start_request), .data_wr(data_wr),
	.status_wr(status_wr), .status_wdata(status_wdata), .sda_oe(sda_oe),
	.transfer_complete_flag(transfer_complete_flag),
	.addressed_as_slave_flag(addressed_as_slave_flag),
	.arbitration_lost_flag(arbitration_lost_flag),
	.bus_interrupt_flag(bus_interrupt_flag),
	.slave_direction_bit(slave_direction_bit), .bus_busy(bus_busy),
	.master_active(master_active), .bus_data_register(bus_data_register),
	.master_launch(master_launch), .bus_irq(bus_irq)
);

// ===== testbench/bus_peer.sv
// Peer master on the two-wire bus: start, stop and bytes at 125 ns per bit.
// Assumes pull-ups on both lines and an open-drain device beside it.
`timescale 1ns/10ps
module bus_peer (
	// Device side
	input  wire dut_sda_oe,
	// Wired bus levels
	output wire scl_line,
	output wire sda_line
);
	reg scl_low;
	reg sda_low;
	reg ack_seen;
	// Released lines float to the pull-up level; SCL idles high
	assign scl_line = ~scl_low;
	assign sda_line = ~(sda_low | dut_sda_oe);
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		ack_seen = 1'b0;
	end
	// ********
	// Bus conditions
	// ********
	task start_cond; begin
		sda_low = 1'b1;
		#60 scl_low = 1'b1;
	end endtask
	task stop_cond; begin
		#30 sda_low = 1'b1;
		#32 scl_low = 1'b0;
		#63 sda_low = 1'b0;
		#60;
	end endtask
	// Start then stop with SCL high throughout: a frame with no bits
	task start_stop; begin
		sda_low = 1'b1;
		#60 sda_low = 1'b0;
		#60;
	end endtask
	task send_byte(input [7:0] b);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				#30 sda_low = ~b[i];
				#32 scl_low = 1'b0;
				#63 scl_low = 1'b1;
			end
			#30 sda_low = 1'b0;
			#32 scl_low = 1'b0;
			#30 ack_seen = ~sda_line;
			#33 scl_low = 1'b1;
			// Flags land a few clocks after the ninth fall; end off the edge
			#31;
		end
	endtask
endmodule // bus_peer

// ===== testbench/i2c_event_and_arbitration_test.sv
// Self-checking bench of the bus event block against a peer master.
// Assumes the checker and peer model are compiled first.
`timescale 1ns/10ps
module i2c_event_and_arbitration_test;
	reg        clk_sys;
	reg        rstn;
	reg        module_enable_bit;
	reg        bus_interrupt_enable;
	reg        general_call_enable;
	reg        ten_bit_mode;
	reg  [9:0] own_address;
	reg        master_select_bit;
	reg        start_request;
	reg        repeat_start_request;
	reg        data_wr;
	reg        status_wr;
	reg  [7:0] status_wdata;
	reg        control_wr;
	reg        stop_request;
	reg        data_rd;
	wire       scl_line;
	wire       sda_line;
	wire       sda_oe;
	wire       transfer_complete_flag;
	wire       addressed_as_slave_flag;
	wire       arbitration_lost_flag;
	wire       bus_interrupt_flag;
	wire       slave_direction_bit;
	wire       bus_busy;
	wire       master_active;
	wire [7:0] bus_data_register;
	wire       bus_irq;
	wire       master_launch;
	reg  [7:0] launch_count;
	wire [7:0] status_bits;
	integer    mismatches;
	integer    check_count;
	integer    i;
	reg [12:0] rows [0:4];
	reg [12:0] row;
	assign status_bits = {transfer_complete_flag, addressed_as_slave_flag,
		arbitration_lost_flag, bus_interrupt_flag, slave_direction_bit,
		bus_busy, master_active, sda_oe};
	i2c_event_core u_i2c_event_core (
		.clk_sys(clk_sys), .rstn(rstn), .scl_in(scl_line), .sda_in(sda_line),
		.sda_out(), .sda_oe(sda_oe), .module_enable_bit(module_enable_bit),
		.bus_interrupt_enable(bus_interrupt_enable),
		.general_call_enable(general_call_enable),
		.ten_bit_mode(ten_bit_mode), .own_address(own_address),
		.master_select_bit(master_select_bit), .transmit_select(1'b0),
		.ack_disable(1'b0), .start_request(start_request),
		.repeat_start_request(repeat_start_request),
		.stop_request(stop_request),
		.data_wr(data_wr), .data_wdata(8'ha5), .data_rd(data_rd),
		.status_wr(status_wr), .status_wdata(status_wdata),
		.control_wr(control_wr),
		.transfer_complete_flag(transfer_complete_flag),
		.addressed_as_slave_flag(addressed_as_slave_flag),
		.arbitration_lost_flag(arbitration_lost_flag),
		.bus_interrupt_flag(bus_interrupt_flag),
		.slave_direction_bit(slave_direction_bit), .bus_busy(bus_busy),
		.master_active(master_active), .bus_data_register(bus_data_register),
		.master_launch(master_launch), .bus_irq(bus_irq)
	);
	bus_peer u_bus_peer (.dut_sda_oe(sda_oe), .scl_line(scl_line),
		.sda_line(sda_line));
	// Launch stands one cycle only, so count the pulses
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			launch_count <= 8'h00;
		else if (master_launch)
			launch_count <= launch_count + 8'h01;
	end
	// ********
	// Tasks
	// ********
	task compare(input [7:0] got, input [7:0] exp); begin
		check_count = check_count + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end endtask
	// Strobes: start, repeat start, stop, data write, data read,
	// status write, control write
	task strobe(input [6:0] s, input [7:0] wd); begin
		@(posedge clk_sys);
		{start_request, repeat_start_request, stop_request, data_wr,
			data_rd, status_wr, control_wr} <= s;
		status_wdata <= wd;
		@(posedge clk_sys);
		{start_request, repeat_start_request, stop_request, data_wr,
			data_rd, status_wr, control_wr} <= 7'h00;
		repeat (2) @(posedge clk_sys);
		#1;
	end endtask
	task summarize; begin
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end endtask
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// A hang counts against the run
	initial begin
		#300000 mismatches = mismatches + 1;
		summarize;
	end
	// ********
	// Sequence
	// ********
	initial begin
		{module_enable_bit, bus_interrupt_enable, general_call_enable} = 3'h0;
		{ten_bit_mode, master_select_bit, start_request} = 3'h0;
		{repeat_start_request, data_wr, status_wr, control_wr} = 4'h0;
		{stop_request, data_rd} = 2'h0;
		status_wdata = 8'h00;
		own_address = 10'h010;
		rstn = 1'b0;
		mismatches = 0;
		check_count = 0;
		// Rows: general call enable, irq enable, byte, ack, irq, direction
		rows[0] = {2'h1, 8'h20, 3'h6};
		rows[1] = {2'h0, 8'h21, 3'h5};
		rows[2] = {2'h3, 8'h00, 3'h6};
		rows[3] = {2'h1, 8'h00, 3'h0};
		rows[4] = {2'h3, 8'h30, 3'h0};
		repeat (11) @(posedge clk_sys);
		#1;
		compare(status_bits, 8'h00);
		compare(bus_data_register, 8'h00);
		compare(bus_irq, 1'b0);
		@(posedge clk_sys);
		rstn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		module_enable_bit <= 1'b1;
		for (i = 0; i < 5; i = i + 1) begin
			row = rows[i];
			@(posedge clk_sys);
			{general_call_enable, bus_interrupt_enable} <= row[12:11];
			u_bus_peer.start_cond;
			u_bus_peer.send_byte(row[10:3]);
			compare(u_bus_peer.ack_seen, row[2]);
			compare(addressed_as_slave_flag, row[2]);
			compare(transfer_complete_flag, row[2]);
			compare(bus_irq, row[1]);
			compare(slave_direction_bit, row[0]);
			if (row[2])
				compare(bus_data_register, row[10:3]);
			u_bus_peer.stop_cond;
			if (i == 0) begin
				strobe(7'h02, 8'hfd);
				compare(bus_interrupt_flag, 1'b1);
				strobe(7'h04, 8'h00);
				compare(transfer_complete_flag, 1'b0);
			end
			strobe(7'h0b, 8'h02);
			compare(status_bits[7:4], 4'h0);
		end
		@(posedge clk_sys);
		{ten_bit_mode, general_call_enable} <= 2'h2;
		own_address <= 10'h2a5;
		u_bus_peer.start_cond;
		u_bus_peer.send_byte(8'hf4);
		compare(u_bus_peer.ack_seen, 1'b1);
		compare({transfer_complete_flag, bus_interrupt_flag}, 2'h3);
		strobe(7'h0b, 8'h02);
		u_bus_peer.send_byte(8'ha5);
		compare({u_bus_peer.ack_seen, addressed_as_slave_flag}, 2'h3);
		compare(slave_direction_bit, 1'b0);
		u_bus_peer.stop_cond;
		strobe(7'h0b, 8'h02);
		@(posedge clk_sys) master_select_bit <= 1'b1;
		u_bus_peer.start_cond;
		strobe(7'h40, 8'h00);
		compare({arbitration_lost_flag, bus_interrupt_flag}, 2'h3);
		strobe(7'h02, 8'h02);
		compare({arbitration_lost_flag, bus_interrupt_flag}, 2'h2);
		strobe(7'h02, 8'h10);
		compare(arbitration_lost_flag, 1'b0);
		u_bus_peer.stop_cond;
		@(posedge clk_sys) master_select_bit <= 1'b0;
		strobe(7'h20, 8'h00);
		compare(arbitration_lost_flag, 1'b1);
		strobe(7'h02, 8'h12);
		@(posedge clk_sys) master_select_bit <= 1'b1;
		strobe(7'h40, 8'h00);
		compare(master_active, 1'b1);
		// Our released first bit meets the peer's low SDA at SCL rise
		u_bus_peer.start_cond;
		u_bus_peer.stop_cond;
		compare({arbitration_lost_flag, master_active, sda_oe}, 3'h4);
		strobe(7'h02, 8'h12);
		strobe(7'h40, 8'h00);
		strobe(7'h10, 8'h00);
		u_bus_peer.start_stop;
		compare({arbitration_lost_flag, master_active}, 2'h0);
		strobe(7'h40, 8'h00);
		u_bus_peer.start_stop;
		compare({arbitration_lost_flag, master_active, sda_oe}, 3'h4);
		strobe(7'h02, 8'h12);
		strobe(7'h40, 8'h00);
		strobe(7'h08, 8'h00);
		compare(launch_count, 8'h01);
		@(posedge clk_sys) rstn <= 1'b0;
		@(posedge clk_sys);
		#1;
		compare(status_bits, 8'h00);
		summarize;
	end
endmodule // i2c_event_and_arbitration_test
